// >>> iq_latency_pkg.sv
// constants, register map and mode encoding for the i/q path latency model
package iq_latency_pkg;

    localparam int DATA_W = 36;
    localparam int LAT_W = 15;
    localparam int DEPTH = 32768;
    localparam int RATE_W = 6;
    localparam int PHASE_W = 4;
    localparam int ADDR_W = 8;

    localparam logic [ADDR_W-1:0] CTRL_OFS = 8'h00;
    localparam logic [ADDR_W-1:0] SYNC_OFS = 8'h04;
    localparam logic [ADDR_W-1:0] LAT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] STATE_OFS = 8'h0C;

    localparam int MODE_LSB = 0;
    localparam int IN_SCALE_BIT = 2;
    localparam int INV_COMB_BIT = 3;
    localparam int COMB_BIT = 4;
    localparam int INV_SINC_BIT = 5;
    localparam int OUT_SCALE_BIT = 6;
    localparam int RATE_LSB = 8;
    localparam int PRESET_LSB = 0;
    localparam int PHASE_LSB = 16;

    localparam logic [31:0] CTRL_RST = 32'h0000_0210;
    localparam logic [RATE_W-1:0] PRESET_RST = 6'h02;

    typedef enum logic [1:0] {MODE_PAR_QUAD, MODE_SERIAL_QUAD, MODE_INTERP_DAC} mode_e;

    localparam logic [RATE_W-1:0] RATE_MIN = 6'h02;
    localparam logic [RATE_W-1:0] N_BYPASS = 6'h01;
    localparam logic [RATE_W-1:0] PRESET_MIN = 6'h02;
    localparam logic [RATE_W-1:0] STATE_LAST = 6'h01;

    localparam logic [LAT_W-1:0] DEMUX_PAR = 15'h0010;
    localparam logic [LAT_W-1:0] DEMUX_DAC = 15'h001C;
    localparam logic [LAT_W-1:0] SCALE_ON = 15'h0008;
    localparam logic [LAT_W-1:0] SCALE_OFF = 15'h0004;
    localparam logic [LAT_W-1:0] SCALE_NONE = 15'h0000;
    localparam logic [LAT_W-1:0] ICOMB_ON = 15'h0008;
    localparam logic [LAT_W-1:0] ICOMB_OFF = 15'h0004;
    localparam logic [LAT_W-1:0] HB_PAR = 15'h0045;
    localparam logic [LAT_W-1:0] HB_SER = 15'h0159;
    localparam logic [LAT_W-1:0] COMB_ON_MUL = 15'h0004;
    localparam logic [LAT_W-1:0] COMB_ON_ADD = 15'h0008;
    localparam logic [LAT_W-1:0] COMB_OFF_MUL = 15'h0002;
    localparam logic [LAT_W-1:0] COMB_OFF_ADD = 15'h0004;
    localparam logic [LAT_W-1:0] MOD_QUAD = 15'h0016;
    localparam logic [LAT_W-1:0] MOD_DAC = 15'h0000;
    localparam logic [LAT_W-1:0] SINC_ON = 15'h0008;
    localparam logic [LAT_W-1:0] SINC_OFF = 15'h0002;
    localparam logic [LAT_W-1:0] OSCALE_ON = 15'h000C;
    localparam logic [LAT_W-1:0] OSCALE_OFF = 15'h0002;
    localparam logic [LAT_W-1:0] DAC_IF = 15'h0008;

endpackage

// >>> clk_state_if.sv
// carrier between the latency model and its clock state generator
`timescale 1ns/1ps
interface clk_state_if;
    import iq_latency_pkg::*;
    logic [RATE_W-1:0] rate;
    logic [RATE_W-1:0] preset;
    logic sync_pulse;
    logic [RATE_W-1:0] state;

    modport ctrl (output rate, output preset, output sync_pulse, input state);
    modport gen (input rate, input preset, input sync_pulse, output state);
endinterface

// >>> clk_state_gen.sv
// presettable rate divider that sets the internal clock state on a sync pulse
`timescale 1ns/1ps
module clk_state_gen
    import iq_latency_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    clk_state_if.gen cs
);

    logic [RATE_W-1:0] state_reg;
    logic [RATE_W-1:0] state_next;
    logic [RATE_W-1:0] preset_applied;

    // preset held inside 2..R whatever software wrote
    assign preset_applied = (cs.preset < PRESET_MIN) ? PRESET_MIN :
                            (cs.preset > cs.rate) ? cs.rate : cs.preset;

    // same preset plus same pulse cycle gives every device the same state
    assign state_next = cs.sync_pulse ? preset_applied :
                        (state_reg <= STATE_LAST) ? cs.rate :
                        state_reg - STATE_LAST;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_reg <= PRESET_RST;
        else
            state_reg <= state_next;
    end

    assign cs.state = state_reg;

endmodule

// >>> iq_path_latency_model.sv
// i/q path latency model: apb registers, latency sum, delay line, sync pulse
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - path delay in clock cycles follows mode and options, comb rate dominating.
// - multiplier N is the comb rate 2..63, or 1 when comb bypassed.
// - serial port mode delay varies per transmission with unknown phase x.
// - assembled input loads a parallel register at the proper instant.
// - demultiplexer adds 16N in parallel mode, 28N in interpolating DAC mode.
// - input scale adds 8N active, 4N bypassed in parallel and DAC modes.
// - input scale is unavailable in serial port mode.
// - inverse comb adds 8N active, 4N bypassed in every mode.
// - half-band chain adds 69N, or 345N in serial port mode.
// - comb stage adds 4N + 8 active, 2N + 4 bypassed.
// - modulator adds 22 in quadrature modes, zero in DAC mode.
// - inverse sinc adds 8 active, 2 bypassed.
// - output scale adds 12 active, 2 bypassed.
// - DAC interface adds a fixed 8.
// - equal sync timing, delay and preset give matching clock states.
// - unison sync pulses put every device in the same state together.
// - sync pulse lasts one cycle and presets the rate down-counter.
// - applied preset is clamped to 2..R.
module iq_path_latency_model
    import iq_latency_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [DATA_W-1:0] iq_in,
    input wire logic iq_in_valid,
    input wire logic frame_sync,
    input wire logic sync_in,
    output logic [DATA_W-1:0] iq_out,
    output logic iq_out_valid,
    output logic sync_pulse,
    output logic [RATE_W-1:0] clock_state
);

    ////////////////////////////////////////////////////////////////////////////
    // latency of one configuration
    function automatic logic [LAT_W-1:0] path_latency(
        input logic [1:0] mode_bits,
        input logic in_scale_en,
        input logic inv_comb_en,
        input logic comb_en,
        input logic inv_sinc_en,
        input logic out_scale_en,
        input logic [RATE_W-1:0] rate,
        input logic [PHASE_W-1:0] phase_x
    );
        logic [LAT_W-1:0] n;
        logic [LAT_W-1:0] demux;
        logic [LAT_W-1:0] in_scale;
        logic [LAT_W-1:0] hb;
        logic [LAT_W-1:0] modul;
        logic [LAT_W-1:0] icomb;
        logic [LAT_W-1:0] comb;
        logic [LAT_W-1:0] fixed;
        n = comb_en ? LAT_W'(rate) : LAT_W'(N_BYPASS);
        icomb = inv_comb_en ? ICOMB_ON : ICOMB_OFF;
        unique case (mode_bits)
            MODE_SERIAL_QUAD:
            begin
                demux = DEMUX_PAR + LAT_W'(phase_x);
                in_scale = SCALE_NONE;
                hb = HB_SER;
                modul = MOD_QUAD;
            end
            MODE_INTERP_DAC:
            begin
                demux = DEMUX_DAC;
                in_scale = in_scale_en ? SCALE_ON : SCALE_OFF;
                hb = HB_PAR;
                modul = MOD_DAC;
            end
            // code 3 is unused and runs as parallel quadrature
            default:
            begin
                demux = DEMUX_PAR;
                in_scale = in_scale_en ? SCALE_ON : SCALE_OFF;
                hb = HB_PAR;
                modul = MOD_QUAD;
            end
        endcase
        comb = comb_en ? LAT_W'(COMB_ON_MUL * n + COMB_ON_ADD)
                       : LAT_W'(COMB_OFF_MUL * n + COMB_OFF_ADD);
        fixed = (inv_sinc_en ? SINC_ON : SINC_OFF)
              + (out_scale_en ? OSCALE_ON : OSCALE_OFF) + DAC_IF;
        // every stage summed; the comb rate scales the large terms
        path_latency = LAT_W'((demux + in_scale + icomb + hb) * n + comb + modul + fixed);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register state
    logic [31:0] ctrl_reg;
    logic [RATE_W-1:0] preset_reg;
    logic [PHASE_W-1:0] phase_cnt_reg;
    logic [PHASE_W-1:0] phase_x_reg;
    logic frame_sync_d_reg;
    logic sync_in_d_reg;
    logic sync_pulse_reg;
    logic [LAT_W-1:0] lat_reg;
    logic [LAT_W-1:0] fill_reg;
    logic [LAT_W-1:0] wr_ptr_reg;
    logic [DATA_W-1:0] iq_out_reg;
    logic iq_out_valid_reg;
    logic [31:0] prdata_reg;
    logic pready_reg;
    logic pslverr_reg;
    logic [DATA_W:0] line_mem [DEPTH];
    clk_state_if cs ();

    ////////////////////////////////////////////////////////////////////////////
    // apb decode
    wire access = psel & penable;
    wire sel_ctrl = (paddr == CTRL_OFS);
    wire sel_sync = (paddr == SYNC_OFS);
    wire sel_lat = (paddr == LAT_OFS);
    wire sel_state = (paddr == STATE_OFS);
    wire mapped = sel_ctrl | sel_sync | sel_lat | sel_state;
    // one wait state so that pready and prdata both come from flops
    wire finish = access & pready_reg;
    wire wr_ctrl = finish & pwrite & sel_ctrl;
    wire wr_sync = finish & pwrite & sel_sync;
    wire [31:0] rd_word = sel_ctrl ? ctrl_reg :
                          sel_sync ? {26'h0, preset_reg} :
                          sel_lat ? {12'h000, phase_x_reg, 1'b0, lat_reg} :
                          sel_state ? {26'h0, cs.state} : 32'h0000_0000;

    ////////////////////////////////////////////////////////////////////////////
    // configuration fields
    wire [1:0] mode_bits = ctrl_reg[MODE_LSB +: 2];
    wire [RATE_W-1:0] rate_raw = ctrl_reg[RATE_LSB +: RATE_W];
    // rates of 0 and 1 are not legal comb rates and run as 2
    wire [RATE_W-1:0] rate_eff = (rate_raw < RATE_MIN) ? RATE_MIN : rate_raw;
    wire serial_mode = (mode_bits == MODE_SERIAL_QUAD);
    wire frame_rise = frame_sync & ~frame_sync_d_reg;
    wire [LAT_W-1:0] lat_next = path_latency(mode_bits, ctrl_reg[IN_SCALE_BIT],
        ctrl_reg[INV_COMB_BIT], ctrl_reg[COMB_BIT], ctrl_reg[INV_SINC_BIT],
        ctrl_reg[OUT_SCALE_BIT], rate_eff, phase_x_reg);
    wire lat_change = (lat_next != lat_reg);
    wire fill_full = (fill_reg >= lat_reg);
    wire [LAT_W-1:0] rd_ptr = wr_ptr_reg - lat_reg;

    ////////////////////////////////////////////////////////////////////////////
    // register bus
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready_reg <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg <= 32'h0000_0000;
        end
        else
        begin
            pready_reg <= access & ~pready_reg;
            pslverr_reg <= access & ~pready_reg & ~mapped;
            prdata_reg <= (access & ~pready_reg & ~pwrite) ? rd_word : 32'h0000_0000;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_reg <= CTRL_RST;
            preset_reg <= PRESET_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl_reg <= {18'h0, pwdata[RATE_LSB +: RATE_W], 1'b0, pwdata[6:0]};
            if (wr_sync)
                preset_reg <= pwdata[PRESET_LSB +: RATE_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // half-band clock phase against the incoming frame sync
    // x is caught on each frame start in serial port mode only, so latency may shift per transmission
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            phase_cnt_reg <= 4'h0;
            phase_x_reg <= 4'h0;
            frame_sync_d_reg <= 1'b0;
        end
        else
        begin
            phase_cnt_reg <= phase_cnt_reg + 4'h1;
            frame_sync_d_reg <= frame_sync;
            if (frame_rise & serial_mode)
                phase_x_reg <= phase_cnt_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sync pulse: one cycle on each rising edge of the sync input
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync_in_d_reg <= 1'b0;
            sync_pulse_reg <= 1'b0;
        end
        else
        begin
            sync_in_d_reg <= sync_in;
            sync_pulse_reg <= sync_in & ~sync_in_d_reg;
        end
    end

    assign cs.rate = rate_eff;
    assign cs.preset = preset_reg;
    assign cs.sync_pulse = sync_pulse_reg;

    clk_state_gen u_gen (
        .pclk(pclk),
        .presetn(presetn),
        .cs(cs)
    );

    ////////////////////////////////////////////////////////////////////////////
    // delay line: circular buffer read at a fixed distance behind the writer
    // a new latency restarts the fill count so no stale sample leaks out
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            lat_reg <= 15'h0000;
            fill_reg <= 15'h0000;
            wr_ptr_reg <= 15'h0000;
        end
        else
        begin
            lat_reg <= lat_next;
            fill_reg <= lat_change ? 15'h0000 : (fill_full ? fill_reg : fill_reg + 15'h0001);
            wr_ptr_reg <= wr_ptr_reg + 15'h0001;
        end
    end

    // the memory write is the parallel load of the assembled sample
    always_ff @(posedge pclk)
    begin
        line_mem[wr_ptr_reg] <= {iq_in_valid, iq_in};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            iq_out_reg <= 36'h0_0000_0000;
            iq_out_valid_reg <= 1'b0;
        end
        else
        begin
            iq_out_reg <= line_mem[rd_ptr][DATA_W-1:0];
            iq_out_valid_reg <= fill_full & ~lat_change & line_mem[rd_ptr][DATA_W];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // outputs
    assign prdata = prdata_reg;
    assign pready = pready_reg;
    assign pslverr = pslverr_reg;
    assign iq_out = iq_out_reg;
    assign iq_out_valid = iq_out_valid_reg;
    assign sync_pulse = sync_pulse_reg;
    assign clock_state = cs.state;

endmodule

// >>> iq_path_latency_model_asserts.sv
// port-level assertion checker for the i/q path latency model
`timescale 1ns/1ps
module iq_path_latency_model_asserts
    import iq_latency_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sync_in,
    input wire logic iq_out_valid,
    input wire logic sync_pulse,
    input wire logic [RATE_W-1:0] clock_state
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    ////////////////////////////////////////////////////////////////////////////
    // shadow of the rate and preset fields, followed from completed writes
    logic [RATE_W-1:0] rate_reg;
    logic [RATE_W-1:0] preset_reg;
    wire wr_ok = psel && penable && pready && pwrite && !pslverr;
    wire [RATE_W-1:0] rate_eff = (rate_reg < RATE_MIN) ? RATE_MIN : rate_reg;
    wire [RATE_W-1:0] preset_lo = (preset_reg < PRESET_MIN) ? PRESET_MIN : preset_reg;
    wire [RATE_W-1:0] preset_eff = (preset_lo > rate_eff) ? rate_eff : preset_lo;
    wire mapped = paddr inside {CTRL_OFS, SYNC_OFS, LAT_OFS, STATE_OFS};

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rate_reg <= CTRL_RST[13:8];
            preset_reg <= PRESET_RST;
        end
        else if (wr_ok && paddr == CTRL_OFS)
            rate_reg <= pwdata[13:8];
        else if (wr_ok && paddr == SYNC_OFS)
            preset_reg <= pwdata[5:0];
    end

    ////////////////////////////////////////////////////////////////////////////
    AST_PREADY_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
        else $error("pready not in second access cycle");
    AST_PREADY_CAUSE: assert property (pready |-> psel && penable && $past(penable))
        else $error("pready without access phase");
    AST_PREADY_ONE: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    AST_ERR_MAP: assert property (pready |-> pslverr == !mapped)
        else $error("pslverr does not match address decode");
    AST_RDATA_IDLE: assert property (!pready || pwrite |-> prdata == 32'h0)
        else $error("read data outside read answer");
    AST_SYNC_PULSE: assert property ($rose(sync_in) |=> sync_pulse ##1 !sync_pulse)
        else $error("sync pulse not one cycle after input edge");
    AST_SYNC_CAUSE: assert property (sync_pulse |-> $past(sync_in) && !$past(sync_in, 2))
        else $error("sync pulse without input edge");
    AST_STATE_PRESET: assert property (sync_pulse |=> clock_state == $past(preset_eff))
        else $error("clock state not clamped preset after sync pulse");
    AST_STATE_DOWN: assert property (!sync_pulse && clock_state > 6'h01
        |=> clock_state == $past(clock_state) - 6'h01)
        else $error("clock state did not count down");
    AST_STATE_RELOAD: assert property (!sync_pulse && clock_state <= STATE_LAST
        |=> clock_state == $past(rate_eff))
        else $error("clock state did not reload rate");

    COV_ERR: cover property (pready && pslverr);
    COV_SYNC: cover property (sync_pulse);
    COV_FILL: cover property ($rose(iq_out_valid));
endmodule

bind iq_path_latency_model iq_path_latency_model_asserts i_asserts (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .sync_in, .iq_out_valid,
    .sync_pulse, .clock_state);

// >>> iq_source.sv
// baseband sample source: counting i/q words and a serial frame marker
`timescale 1ns/1ps
module iq_source
    import iq_latency_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic frame_req,
    output logic [DATA_W-1:0] iq_in,
    output logic iq_in_valid,
    output logic frame_sync
);
    // counting words let the bench read the exact delay of any sample
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            iq_in <= '0;
            iq_in_valid <= 1'b0;
            frame_sync <= 1'b0;
        end
        else
        begin
            iq_in <= iq_in + 36'h1;
            iq_in_valid <= 1'b1;
            frame_sync <= frame_req;
        end
    end
endmodule

// >>> iq_path_latency_model_bench.sv
// self-checking bench for the i/q path latency model
`timescale 1ns/1ps
module iq_path_latency_model_bench
    import iq_latency_pkg::*;
;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, sync_in, frame_req, er;
    logic [ADDR_W-1:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic pready, pslverr, iq_in_valid, iq_out_valid, frame_sync, sync_pulse;
    logic [DATA_W-1:0] iq_in, iq_out;
    logic [RATE_W-1:0] clock_state;
    int err_total, cmp_count;
    // edges since reset release; its low bits track the free-running phase
    int cyc = 0;
    localparam logic [31:0] CFG [7] = '{32'h0000_1430, 32'h0000_3F7C, 32'h0000_0A7D,
        32'h0000_0002, 32'h0000_0156, 32'h0000_0001, 32'h0000_052B};

    iq_path_latency_model i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .iq_in, .iq_in_valid, .frame_sync, .sync_in, .iq_out,
        .iq_out_valid, .sync_pulse, .clock_state);
    iq_source i_src (.pclk, .presetn, .frame_req, .iq_in, .iq_in_valid, .frame_sync);

    initial
    begin
        forever #2 pclk = ~pclk;
    end

    always @(posedge pclk)
    begin
        cyc <= presetn ? cyc + 1 : 0;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [14:0] exp_lat(input logic [31:0] c, input logic [3:0] x);
        int m = (c[1:0] == 2'h3) ? 0 : int'(c[1:0]);
        int r = (c[13:8] < 6'h02) ? 2 : int'(c[13:8]);
        int n = c[4] ? r : 1;
        int s = (m == 1) ? 16 + int'(x) + 345 : ((m == 2) ? 28 + 69 : 16 + 69);
        s = (s + (m == 1 ? 0 : (c[2] ? 8 : 4)) + (c[3] ? 8 : 4)) * n;
        s += (c[4] ? 4 * n + 8 : 2 * n + 4) + (m == 2 ? 0 : 22);
        s += (c[5] ? 8 : 2) + (c[6] ? 12 : 2) + 8;
        return 15'(s);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, CTRL_RST);
        apb(1'b0, SYNC_OFS, 32'h0);
        chk(rd, {26'h0, PRESET_RST});
        apb(1'b0, LAT_OFS, 32'h0);
        chk(rd[14:0], exp_lat(CTRL_RST, 4'h0));
    endtask

    // counting words make iq_out lag the live input by latency plus one
    task automatic t_data(input int l);
        while (iq_out_valid !== 1'b1) @(negedge pclk);
        repeat (16)
        begin
            @(negedge pclk);
            chk(iq_out, iq_in - 36'(l + 1));
        end
    endtask

    task automatic t_refill;
        apb(1'b1, CTRL_OFS, 32'h0000_0002);
        repeat (2) @(negedge pclk);
        chk(iq_out_valid, 1'b0);
        t_data(int'(exp_lat(32'h0000_0002, 4'h0)));
    endtask

    task automatic t_table;
        logic [3:0] x_last = 4'h0;
        foreach (CFG[i])
        begin
            apb(1'b1, CTRL_OFS, CFG[i]);
            repeat (i + 1) @(posedge pclk);
            frame_req <= 1'b1;
            @(posedge pclk);
            frame_req <= 1'b0;
            // marker reaches the pin now and is caught one edge later
            if (CFG[i][1:0] == 2'h1)
                x_last = 4'(cyc + 1);
            repeat (3) @(posedge pclk);
            apb(1'b0, CTRL_OFS, 32'h0);
            chk(rd, CFG[i] & 32'h0000_3F7F);
            apb(1'b0, LAT_OFS, 32'h0);
            chk(rd[14:0], exp_lat(CFG[i], x_last));
            chk(rd[19:16], x_last);
            chk({rd[31:20], rd[15]}, 36'h0);
        end
    endtask

    task automatic t_refused;
        apb(1'b1, LAT_OFS, 32'hFFFF_FFFF);
        apb(1'b0, LAT_OFS, 32'h0);
        chk(rd[14:0], exp_lat(CFG[6], 4'h0));
        apb(1'b0, 8'h10, 32'h0);
        chk({er, rd}, {1'b1, 32'h0});
        apb(1'b1, 8'h40, 32'h1234_5678);
        chk(er, 1'b1);
    endtask

    task automatic t_sync;
        logic [5:0] pre [5] = '{6'h00, 6'h01, 6'h05, 6'h28, 6'h3F};
        logic [5:0] exp [5] = '{6'h02, 6'h02, 6'h05, 6'h14, 6'h14};
        apb(1'b1, CTRL_OFS, 32'h0000_1410);
        foreach (pre[i])
        begin
            apb(1'b1, SYNC_OFS, {26'h0, pre[i]});
            @(posedge pclk);
            sync_in <= 1'b1;
            @(posedge pclk);
            @(negedge pclk);
            chk(sync_pulse, 1'b1);
            @(negedge pclk);
            chk(clock_state, exp[i]);
            chk(sync_pulse, 1'b0);
            @(posedge pclk);
            sync_in <= 1'b0;
            @(negedge pclk);
            chk(clock_state, exp[i] - 6'h01);
        end
        apb(1'b0, STATE_OFS, 32'h0);
        chk(rd[31:6], 36'h0);
    endtask

    task automatic report_and_stop;
        if (err_total == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        sync_in = 1'b0;
        frame_req = 1'b0;
        presetn = 1'b0;
        err_total = 0;
        cmp_count = 0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        t_reset;
        t_data(int'(exp_lat(CTRL_RST, 4'h0)));
        t_refill;
        t_table;
        t_refused;
        t_sync;
        report_and_stop;
    end

    // whole run needs under a thousand cycles; this allows ample margin
    initial
    begin
        #200000;
        err_total++;
        report_and_stop;
    end
endmodule
